// [rtl/sdram_pkg.sv]
package sdram_pkg;

  localparam int DATA_W          = 16;
  localparam int ADDR_W          = 10;
  localparam int ROW_W           = 9;
  localparam int COL_W           = 8;
  localparam int BANK_BIT        = 9;
  localparam int ALL_BIT         = 8;
  localparam int FIFO_DEPTH      = 16;
  localparam int LAT_STAGES      = 3;
  localparam int MASK_READ_DELAY = 2;
  localparam int LAT_LO          = 4;
  localparam int LAT_HI          = 5;
  localparam int BL_LO           = 0;
  localparam int BL_HI           = 2;

  localparam logic [ADDR_W-1:0] MODE_RESET = 10'h020;
  localparam logic [3:0]        MODE_WAIT  = 4'h2;
  localparam logic [3:0]        RC_L3      = 4'h9;
  localparam logic [3:0]        RC_L2      = 4'h6;
  localparam logic [3:0]        RC_L1      = 4'h3;
  localparam logic [2:0]        BL_FULL    = 3'h7;
  localparam logic [8:0]        FULL_PAGE  = 9'h100;

  typedef enum logic [3:0] {
    C_DESEL   = 4'b0000,
    C_IDLE    = 4'b0001,
    C_MODE    = 4'b0010,
    C_REFRESH = 4'b0011,
    C_CLOSE   = 4'b0100,
    C_OPEN    = 4'b0101,
    C_READ    = 4'b0110,
    C_WRITE   = 4'b0111,
    C_HALT    = 4'b1000
  } cmd_t;

  typedef enum logic [2:0] {
    ST_READY = 3'b000,
    ST_RD    = 3'b001,
    ST_WR    = 3'b010,
    ST_RFSH  = 3'b011,
    ST_SELF  = 3'b100,
    ST_MODE  = 3'b101
  } dev_state_t;

  typedef struct packed {
    logic              clock_gate;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [1:0]        byte_mask;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } pins_t;

  typedef struct packed {
    logic             bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } cell_addr_t;

  typedef struct packed {
    cell_addr_t        where;
    logic [DATA_W-1:0] data;
    logic [1:0]        byte_en;
  } store_word_t;

  localparam int STORE_W = $bits(store_word_t);

  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_t c;
    c = C_IDLE;
    if (cs_n)
      c = C_DESEL;
    else
    begin
      case ({ras_n, cas_n, we_n})
        3'h0:    c = C_MODE;
        3'h1:    c = C_REFRESH;
        3'h2:    c = C_CLOSE;
        3'h3:    c = C_OPEN;
        3'h4:    c = C_WRITE;
        3'h5:    c = C_READ;
        3'h6:    c = C_HALT;
        default: c = C_IDLE;
      endcase
    end
    return c;
  endfunction : decode_cmd

  function automatic logic [8:0] burst_words(input logic [2:0] code);
    logic [8:0] w;
    w = 9'h001;
    if (code == BL_FULL)
      w = FULL_PAGE;
    else if (code < 3'h4)
      w = 9'h001 << code;
    return w;
  endfunction : burst_words

  function automatic logic [1:0] col_lat(input logic [1:0] field);
    return (field == 2'h0) ? 2'h1 : field;
  endfunction : col_lat

  function automatic logic [3:0] row_cycle(input logic [1:0] lat);
    logic [3:0] rc;
    rc = RC_L1;
    if (lat == 2'h3)
      rc = RC_L3;
    else if (lat == 2'h2)
      rc = RC_L2;
    return rc;
  endfunction : row_cycle

endpackage : sdram_pkg

// [rtl/word_fifo.sv]
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rst_n,     // Async reset, low
  input  wire logic             in_valid,  // Fill side valid
  output logic                  in_ready,  // Fill side has room
  input  wire logic [WIDTH-1:0] in_data,   // Fill side word
  output logic                  out_valid, // Drain side valid
  input  wire logic             out_ready, // Drain side takes word
  output logic      [WIDTH-1:0] out_data   // Drain side word
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
  } ptr_t;

  ptr_t             r;
  ptr_t             n;
  logic [WIDTH-1:0] mem [DEPTH];

  always_comb
  begin
    n = r;
    in_ready  = !((r.wp[PW] != r.rp[PW]) && (r.wp[PW-1:0] == r.rp[PW-1:0]));
    out_valid = (r.wp != r.rp);
    if (in_valid && in_ready)
      n.wp = r.wp + 1'b1;
    if (out_valid && out_ready)
      n.rp = r.rp + 1'b1;
  end

  assign out_data = mem[r.rp[PW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem[r.wp[PW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

endmodule : word_fifo

// [rtl/read_pipe.sv]
`timescale 1ns/10ps
module read_pipe (
  input  wire logic                           clk,         // System clock
  input  wire logic                           rst_n,       // Async reset, low
  input  wire logic                           fetch_valid, // Word fetched now
  input  wire logic [sdram_pkg::DATA_W-1:0]   fetch_data,  // Fetched word
  input  wire logic [1:0]                     lat,         // Column latency 1..3
  input  wire logic [1:0]                     byte_mask,   // Masks, high then low
  output logic      [sdram_pkg::DATA_W-1:0]   out_data,    // Word on the pins
  output logic      [1:0]                     out_oe,      // Per byte drive
  output logic                                out_vld      // Burst word present
);
  typedef struct packed {
    logic [sdram_pkg::LAT_STAGES-1:0]                            vld;
    logic [sdram_pkg::LAT_STAGES-1:0][sdram_pkg::DATA_W-1:0]     data;
    logic [sdram_pkg::MASK_READ_DELAY-1:0][1:0]                  mask;
  } pipe_t;

  pipe_t      r;
  pipe_t      n;
  logic [1:0] tap;

  always_comb
  begin
    n = r;
    n.vld[0]  = fetch_valid;
    n.data[0] = fetch_data;
    n.mask[0] = byte_mask;
    for (int i = 1; i < sdram_pkg::LAT_STAGES; i++)
    begin
      n.vld[i]  = r.vld[i-1];
      n.data[i] = r.data[i-1];
    end
    for (int i = 1; i < sdram_pkg::MASK_READ_DELAY; i++)
      n.mask[i] = r.mask[i-1];
  end

  // Word fetched in cycle f reaches the pins in cycle f + lat
  assign tap      = lat - 2'h1;
  assign out_vld  = r.vld[tap];
  assign out_data = r.data[tap];
  assign out_oe   = {2{r.vld[tap]}} & ~r.mask[sdram_pkg::MASK_READ_DELAY-1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

endmodule : read_pipe

// [rtl/sdram_cmd_timing.sv]
`timescale 1ns/10ps
module sdram_cmd_timing (
  input  wire logic                            CLK,             // 50 MHz clock
  input  wire logic                            RESET_N,         // Async reset
  input  wire logic                            CLOCK_GATE,      // Clock gate pin
  input  wire logic                            CHIP_SELECT_N,   // Chip select
  input  wire logic                            ROW_STROBE_N,    // Row strobe
  input  wire logic                            COLUMN_STROBE_N, // Column strobe
  input  wire logic                            WRITE_STROBE_N,  // Write strobe
  input  wire logic [1:0]                      BYTE_MASK,       // High, low mask
  input  wire logic [sdram_pkg::ADDR_W-1:0]    ADDR,            // Address pins
  input  wire logic [sdram_pkg::DATA_W-1:0]    DQ_IN,           // Data pins in
  output logic      [sdram_pkg::DATA_W-1:0]    DQ_OUT,          // Data pins out
  output logic      [1:0]                      DQ_OE,           // Byte drive
  output logic                                 FETCH_VALID,     // Array read now
  output sdram_pkg::cell_addr_t                FETCH_REQ,       // Array address
  input  wire logic [sdram_pkg::DATA_W-1:0]    FETCH_DATA,      // Array word
  output logic                                 STORE_VALID,     // Store word ready
  input  wire logic                            STORE_READY,     // Array takes word
  output sdram_pkg::store_word_t               STORE_WORD,      // Store word
  output logic                                 STORE_SPACE,     // Buffer has room
  output logic                                 BUSY,            // Wait running
  output logic                                 SELF_REFRESH,    // In self refresh
  output logic      [1:0]                      BANK_OPEN,       // Open banks
  output logic      [sdram_pkg::ADDR_W-1:0]    MODE_WORD        // Mode register
);

  typedef struct packed {
    sdram_pkg::pins_t                          s1;
    sdram_pkg::pins_t                          s2;
    logic                                      cke_prev;
    sdram_pkg::dev_state_t                     state;
    logic [sdram_pkg::ADDR_W-1:0]              mode;
    logic [1:0]                                open;
    logic [1:0][sdram_pkg::ROW_W-1:0]          row;
    logic                                      bank;
    logic [sdram_pkg::COL_W-1:0]               col;
    logic [8:0]                                left;
    logic                                      close_after;
    logic [3:0]                                wait_cnt;
  } ctl_t;

  ctl_t                          r;
  ctl_t                          n;
  sdram_pkg::cmd_t               cmd;
  logic                          cmd_en;
  logic                          busy_w;
  logic                          bsel;
  logic [1:0]                    lat;
  logic                          act_rd;
  logic                          act_wr;
  logic                          act_bank;
  logic [sdram_pkg::COL_W-1:0]   act_col;
  logic                          push;
  sdram_pkg::store_word_t        store_in;
  logic [sdram_pkg::STORE_W-1:0] store_out;
  logic                          rd_vld;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode on the synchronised pins

  assign cmd    = sdram_pkg::decode_cmd(r.s2.cs_n, r.s2.ras_n, r.s2.cas_n, r.s2.we_n);
  assign busy_w = (r.state == sdram_pkg::ST_RFSH) || (r.state == sdram_pkg::ST_SELF)
                  || (r.state == sdram_pkg::ST_MODE);
  // Commands are only sampled with the clock gate high on the previous edge
  assign cmd_en = r.cke_prev && !busy_w;
  assign bsel   = r.s2.addr[sdram_pkg::BANK_BIT];
  assign lat    = sdram_pkg::col_lat(r.mode[sdram_pkg::LAT_HI:sdram_pkg::LAT_LO]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    n = r;
    n.s1 = '{CLOCK_GATE, CHIP_SELECT_N, ROW_STROBE_N, COLUMN_STROBE_N,
             WRITE_STROBE_N, BYTE_MASK, ADDR, DQ_IN};
    n.s2 = r.s1;
    n.cke_prev = r.s2.clock_gate;
    act_rd   = 1'b0;
    act_wr   = 1'b0;
    act_bank = r.bank;
    act_col  = r.col;

    case (r.state)
      sdram_pkg::ST_RD, sdram_pkg::ST_WR:
      begin
        act_rd = (r.state == sdram_pkg::ST_RD);
        act_wr = (r.state == sdram_pkg::ST_WR);
        n.col  = r.col + 1'b1;
        n.left = r.left - 9'h001;
        if (r.left == 9'h001)
        begin
          n.state = sdram_pkg::ST_READY;
          if (r.close_after)
            n.open[r.bank] = 1'b0;
        end
      end
      sdram_pkg::ST_RFSH, sdram_pkg::ST_MODE:
      begin
        if (r.wait_cnt <= 4'h1)
          n.state = sdram_pkg::ST_READY;
        else
          n.wait_cnt = r.wait_cnt - 4'h1;
      end
      sdram_pkg::ST_SELF:
      begin
        // Rising clock gate ends self refresh; recovery counts like a refresh
        if (r.s2.clock_gate)
        begin
          n.state    = sdram_pkg::ST_RFSH;
          n.wait_cnt = sdram_pkg::row_cycle(lat) - 4'h1;
        end
      end
      default:
      begin
        n.state = r.state;
      end
    endcase

    if (cmd_en)
    begin
      case (cmd)
        sdram_pkg::C_MODE:
        begin
          n.mode     = r.s2.addr;
          n.state    = sdram_pkg::ST_MODE;
          n.wait_cnt = sdram_pkg::MODE_WAIT - 4'h1;
          act_rd     = 1'b0;
          act_wr     = 1'b0;
        end
        sdram_pkg::C_OPEN:
        begin
          n.open[bsel] = 1'b1;
          n.row[bsel]  = r.s2.addr[sdram_pkg::ROW_W-1:0];
        end
        sdram_pkg::C_CLOSE:
        begin
          if (r.s2.addr[sdram_pkg::ALL_BIT])
            n.open = 2'h0;
          else
            n.open[bsel] = 1'b0;
          // Closing the burst bank cuts it: no more fetches, write data dropped
          if ((act_rd || act_wr) && (r.s2.addr[sdram_pkg::ALL_BIT] || bsel == r.bank))
          begin
            act_rd  = 1'b0;
            act_wr  = 1'b0;
            n.state = sdram_pkg::ST_READY;
          end
        end
        sdram_pkg::C_READ, sdram_pkg::C_WRITE:
        begin
          // A new column command to an open bank replaces any running burst
          if (r.open[bsel])
          begin
            act_rd        = (cmd == sdram_pkg::C_READ);
            act_wr        = (cmd == sdram_pkg::C_WRITE);
            act_bank      = bsel;
            act_col       = r.s2.addr[sdram_pkg::COL_W-1:0];
            n.bank        = bsel;
            n.col         = act_col + 1'b1;
            n.close_after = r.s2.addr[sdram_pkg::ALL_BIT];
            n.left        = sdram_pkg::burst_words(
                              r.mode[sdram_pkg::BL_HI:sdram_pkg::BL_LO]) - 9'h001;
            if (n.left == 9'h000)
            begin
              n.state = sdram_pkg::ST_READY;
              if (r.s2.addr[sdram_pkg::ALL_BIT])
                n.open[bsel] = 1'b0;
            end
            else if (cmd == sdram_pkg::C_READ)
              n.state = sdram_pkg::ST_RD;
            else
              n.state = sdram_pkg::ST_WR;
          end
        end
        sdram_pkg::C_HALT:
        begin
          if (act_rd || act_wr)
          begin
            act_rd  = 1'b0;
            act_wr  = 1'b0;
            n.state = sdram_pkg::ST_READY;
          end
        end
        sdram_pkg::C_REFRESH:
        begin
          if (r.open == 2'h0 && r.state == sdram_pkg::ST_READY)
          begin
            if (r.s2.clock_gate)
            begin
              n.state    = sdram_pkg::ST_RFSH;
              n.wait_cnt = sdram_pkg::row_cycle(lat) - 4'h1;
            end
            else
              n.state = sdram_pkg::ST_SELF;
          end
        end
        default:
        begin
          n.state = n.state;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      r      <= '0;
      r.mode <= sdram_pkg::MODE_RESET;
    end
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array side and data pins

  assign FETCH_VALID = act_rd;
  assign FETCH_REQ   = '{act_bank, r.row[act_bank], act_col};
  // Write mask applies to the word in the same cycle
  assign store_in    = '{FETCH_REQ, r.s2.dq, ~r.s2.byte_mask};
  // No way to stall the controller, so a word meeting a full buffer is lost
  assign push        = act_wr;

  word_fifo #(
    .WIDTH (sdram_pkg::STORE_W),
    .DEPTH (sdram_pkg::FIFO_DEPTH)
  ) u_store_fifo (
    .clk       (CLK),
    .rst_n     (RESET_N),
    .in_valid  (push),
    .in_ready  (STORE_SPACE),
    .in_data   (store_in),
    .out_valid (STORE_VALID),
    .out_ready (STORE_READY),
    .out_data  (store_out)
  );

  assign STORE_WORD = store_out;

  read_pipe u_read_pipe (
    .clk         (CLK),
    .rst_n       (RESET_N),
    .fetch_valid (act_rd),
    .fetch_data  (FETCH_DATA),
    .lat         (lat),
    .byte_mask   (r.s2.byte_mask),
    .out_data    (DQ_OUT),
    .out_oe      (DQ_OE),
    .out_vld     (rd_vld)
  );

  assign BUSY         = busy_w;
  assign SELF_REFRESH = (r.state == sdram_pkg::ST_SELF);
  assign BANK_OPEN    = r.open;
  assign MODE_WORD    = r.mode;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_cmd(sdram_pkg::cmd_t c);
    cmd_en && (cmd == c);
  endsequence

  sequence s_read_ok;
    s_cmd(sdram_pkg::C_READ) ##0 r.open[bsel];
  endsequence

  a_mode_load: assert property (s_cmd(sdram_pkg::C_MODE) |=>
    (r.mode == $past(r.s2.addr)) && BUSY ##1 !BUSY)
    else $error("mode word not loaded");

  a_open_row: assert property (s_cmd(sdram_pkg::C_OPEN) |=>
    r.open[$past(bsel)] && (r.row[$past(bsel)] == $past(r.s2.addr[sdram_pkg::ROW_W-1:0])))
    else $error("row not opened");

  a_close_all: assert property (s_cmd(sdram_pkg::C_CLOSE) ##0
    r.s2.addr[sdram_pkg::ALL_BIT] |=> r.open == 2'h0)
    else $error("close all left a bank open");

  a_close_one: assert property (s_cmd(sdram_pkg::C_CLOSE) ##0
    !r.s2.addr[sdram_pkg::ALL_BIT] |=> !r.open[$past(bsel)])
    else $error("selected bank still open");

  a_read_issue: assert property (s_read_ok |-> FETCH_VALID &&
    (FETCH_REQ.col == r.s2.addr[sdram_pkg::COL_W-1:0]) && (FETCH_REQ.bank == bsel))
    else $error("read fetch wrong");

  a_read_lat3: assert property (s_read_ok ##0 (lat == 2'h3) |-> ##3 rd_vld)
    else $error("read data not after latency");

  a_back_to_back: assert property (s_read_ok ##1 s_read_ok |-> FETCH_VALID &&
    (FETCH_REQ.col == r.s2.addr[sdram_pkg::COL_W-1:0]))
    else $error("back to back read dropped");

  a_float_lat3: assert property ((!FETCH_VALID && lat == 2'h3)[*3] |=> DQ_OE == 2'h0)
    else $error("outputs still driven");

  a_halt_write: assert property (s_cmd(sdram_pkg::C_HALT) ##0
    (r.state == sdram_pkg::ST_WR) |-> !push ##1 (r.state == sdram_pkg::ST_READY))
    else $error("write not halted");

  a_close_write: assert property (s_cmd(sdram_pkg::C_CLOSE) ##0
    (r.state == sdram_pkg::ST_WR && (r.s2.addr[sdram_pkg::ALL_BIT] || bsel == r.bank))
    |-> !push)
    else $error("write data kept after close");

  a_mask_read: assert property (r.s2.byte_mask[0] |-> ##2 !DQ_OE[0])
    else $error("low byte driven under mask");

  a_mask_write: assert property (push |-> store_in.byte_en == ~r.s2.byte_mask)
    else $error("write mask not immediate");

  a_idle_keep: assert property ((s_cmd(sdram_pkg::C_IDLE) or s_cmd(sdram_pkg::C_DESEL))
    ##0 (r.state == sdram_pkg::ST_READY) |=>
    (r.open == $past(r.open)) && (r.mode == $past(r.mode)) && (r.state == sdram_pkg::ST_READY))
    else $error("idle changed state");

  a_refresh_hold: assert property (s_cmd(sdram_pkg::C_REFRESH) ##0
    (r.open == 2'h0 && r.state == sdram_pkg::ST_READY && r.s2.clock_gate && lat == 2'h3)
    |=> BUSY[*8] ##1 !BUSY)
    else $error("refresh wait wrong");

  a_self_exit: assert property ((r.state == sdram_pkg::ST_SELF) && r.s2.clock_gate
    |=> (r.state == sdram_pkg::ST_RFSH) && BUSY)
    else $error("self refresh exit wrong");

endmodule : sdram_cmd_timing

// [test/array_model.sv]
`timescale 1ns/10ps
module array_model (
  input  wire logic                   clk,         // System clock
  input  wire logic                   stall,       // Hold off stores
  input  wire logic                   fetch_valid, // Read request
  input  wire sdram_pkg::cell_addr_t  fetch_req,   // Read address
  output logic [15:0]                 fetch_data,  // Read word
  input  wire logic                   store_valid, // Store word offered
  output logic                        store_ready, // Store word taken
  input  wire sdram_pkg::store_word_t store_word   // Store word
);
  logic [15:0] mem [0:262143];
  logic [15:0] noise = 16'h5a5a;
  initial
  begin
    for (int i = 0; i < 262144; i++)
      mem[i] = 16'h0000;
  end
  // Outside a fetch the bus shows a changing pattern, never a held word
  assign fetch_data  = fetch_valid ? mem[fetch_req] : noise;
  assign store_ready = !stall;
  always @(posedge clk)
  begin
    noise <= ~noise;
    if (store_valid && store_ready)
    begin
      if (store_word.byte_en[1])
        mem[store_word.where][15:8] <= store_word.data[15:8];
      if (store_word.byte_en[0])
        mem[store_word.where][7:0] <= store_word.data[7:0];
    end
  end
endmodule : array_model

// [test/sdram_command_timing_tb_top.sv]
`timescale 1ns/10ps
module sdram_command_timing_tb_top;
  logic                   clk, rst_n, gate, cs_n, stall, fvld, svld, srdy, sspace, busy, selfr;
  logic [2:0]             rcw;
  logic [1:0]             mask, dq_oe, bopen;
  logic [9:0]             addr, mword;
  logic [15:0]            dq_in, dq_out, fdata;
  sdram_pkg::cell_addr_t  freq;
  sdram_pkg::store_word_t sword;
  int                     num_errors = 0;
  int                     samples_checked = 0;
  int                     n;

  sdram_cmd_timing u_sdram_cmd_timing (.CLK(clk), .RESET_N(rst_n), .CLOCK_GATE(gate),
    .CHIP_SELECT_N(cs_n), .ROW_STROBE_N(rcw[2]), .COLUMN_STROBE_N(rcw[1]),
    .WRITE_STROBE_N(rcw[0]), .BYTE_MASK(mask), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .FETCH_VALID(fvld), .FETCH_REQ(freq), .FETCH_DATA(fdata),
    .STORE_VALID(svld), .STORE_READY(srdy), .STORE_WORD(sword), .STORE_SPACE(sspace),
    .BUSY(busy), .SELF_REFRESH(selfr), .BANK_OPEN(bopen), .MODE_WORD(mword));
  array_model u_array_model (.clk(clk), .stall(stall), .fetch_valid(fvld), .fetch_req(freq),
    .fetch_data(fdata), .store_valid(svld), .store_ready(srdy), .store_word(sword));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_sig(ref logic sig, input logic v);
    int k;
    k = 0;
    while (sig !== v && k < 2000)
    begin
      step(1);
      k++;
    end
    if (k == 2000)
    begin
      check("wait bound", 0, 1);
      wrap_up();
    end
  endtask : wait_sig
  // Deselect between commands keeps the pins defined during every wait
  task automatic cmd(input logic [2:0] c, input logic [9:0] a);
    cs_n = 1'b0;
    rcw = c;
    addr = a;
    step(1);
    cs_n = 1'b1;
  endtask : cmd
  task automatic busy_run(input string what, input int exp);
    wait_sig(busy, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < 50)
    begin
      step(1);
      n++;
    end
    check(what, n, exp);
  endtask : busy_run
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_write_read;
    logic [15:0] w [4];
    logic [1:0]  e;
    logic [15:0] b;
    w = '{16'h1234, 16'h5678, 16'h9a00, 16'hdef0};
    stall = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      cs_n = (j != 0);
      rcw = (j == 0) ? 3'b100 : 3'b111;
      addr = 10'h00a;
      dq_in = (j == 2) ? 16'h9abc : w[j];
      mask = (j == 2) ? 2'b01 : 2'b00;
      step(1);
    end
    cs_n = 1'b1;
    mask = 2'b00;
    wait_sig(svld, 1'b1);
    check("store word", sword, {1'b0, 9'h005, 8'h0a, 16'h1234, 2'b11});
    stall = 1'b0;
    wait_sig(svld, 1'b0);
    cmd(3'b101, 10'h00a);
    mask = 2'b01;
    step(1);
    mask = 2'b00;
    wait_sig(fvld, 1'b1);
    step(2);
    for (int j = 0; j < 4; j++)
    begin
      e = (j == 1) ? 2'b10 : 2'b11;
      b = {{8{e[1]}}, {8{e[0]}}};
      check("read enable", dq_oe, e);
      check("read data", dq_out & b, w[j] & b);
      step(1);
    end
    check("read end", dq_oe, 2'b00);
    // Second read replaces the first after a single word
    cs_n = 1'b0;
    rcw = 3'b101;
    addr = 10'h00d;
    step(1);
    addr = 10'h00a;
    step(1);
    cs_n = 1'b1;
    wait_sig(fvld, 1'b1);
    step(2);
    check("first of pair", dq_out, w[3]);
    step(1);
    check("second of pair", dq_out, w[0]);
  endtask : t_write_read
  task automatic t_latency;
    for (int l = 1; l < 4; l++)
    begin
      cmd(3'b000, {4'h0, 2'(l), 4'h3});
      busy_run("mode wait", 1);
      cmd(3'b001, 10'h000);
      busy_run("refresh wait", 3 * l - 1);
      cmd(3'b011, 10'h005);
      step(l);
      cmd(3'b101, 10'h10a);
      wait_sig(fvld, 1'b1);
      n = 0;
      while (dq_oe === 2'b00 && n < 8)
      begin
        step(1);
        n++;
      end
      check("read latency", n, l);
      step(10);
      check("auto close", bopen, 2'b00);
    end
  endtask : t_latency
  task automatic t_halt_fifo;
    cmd(3'b000, 10'h037);
    busy_run("mode wait", 1);
    cmd(3'b011, 10'h005);
    step(3);
    cmd(3'b101, 10'h00a);
    step(1);
    cmd(3'b110, 10'h000);
    n = 0;
    for (int j = 0; j < 12; j++)
    begin
      n += (dq_oe != 2'b00);
      step(1);
    end
    check("halt words", n, 2);
    check("halt keeps bank", bopen, 2'b01);
    stall = 1'b1;
    dq_in = 16'h0f0f;
    cmd(3'b100, 10'h000);
    wait_sig(sspace, 1'b0);
    step(4);
    cmd(3'b110, 10'h000);
    step(3);
    stall = 1'b0;
    n = 0;
    while (svld === 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    check("drained words", n, 16);
    check("space back", sspace, 1'b1);
    // Leave a long write running for the close that follows
    cmd(3'b100, 10'h000);
    step(2);
  endtask : t_halt_fifo
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    gate = 1'b1;
    cs_n = 1'b1;
    rcw = 3'b111;
    mask = 2'b00;
    addr = 10'h000;
    dq_in = 16'h0000;
    stall = 1'b0;
    step(6);
    rst_n = 1'b1;
    check("reset mode", {mword, bopen, busy, dq_oe, sspace}, {10'h020, 2'b00, 1'b0, 2'b00, 1'b1});
    step(1);
    cmd(3'b000, 10'h022);
    busy_run("mode busy", 1);
    check("mode word", mword, 10'h022);
    cmd(3'b011, 10'h005);
    step(2);
    cmd(3'b011, 10'h20a);
    step(3);
    check("banks open", bopen, 2'b11);
    t_write_read();
    cmd(3'b010, 10'h200);
    step(3);
    check("close one", bopen, 2'b01);
    cmd(3'b010, 10'h300);
    step(3);
    check("close both", bopen, 2'b00);
    t_latency();
    t_halt_fifo();
    cmd(3'b010, 10'h100);
    step(3);
    check("close cuts write", {svld, bopen}, 3'b000);
    gate = 1'b0;
    cmd(3'b001, 10'h000);
    wait_sig(selfr, 1'b1);
    step(20);
    check("self busy", busy, 1'b1);
    gate = 1'b1;
    wait_sig(selfr, 1'b0);
    wait_sig(busy, 1'b0);
    // Refresh position is unknown after self refresh, so sweep every row
    for (int j = 0; j < 1024; j++)
    begin
      cmd(3'b001, 10'h000);
      busy_run("recharge pass", 8);
    end
    cmd(3'b111, 10'h3ff);
    step(3);
    check("idle no change", {mword, bopen}, {10'h037, 2'b00});
    wrap_up();
  end
endmodule : sdram_command_timing_tb_top
